//--- pkg/snsp_burst_if.sv
// Interface between the port core and its burst address counter.
`timescale 1ns/10ps
interface snsp_burst_if;
    logic                          load;
    logic                          advance;
    logic                          linear;
    logic [snsp_pkg::BURST_W-1:0]  start_bits;
    logic [snsp_pkg::BURST_W-1:0]  cur_bits;

    modport counter (
        input  load,
        input  advance,
        input  linear,
        input  start_bits,
        output cur_bits
    );
    modport user (
        output load,
        output advance,
        output linear,
        output start_bits,
        input  cur_bits
    );
endinterface : snsp_burst_if

//--- pkg/snsp_pkg.sv
// Constants and types shared by the synchronous no-turnaround SRAM port.
package snsp_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 18;
    localparam int LANES   = 4;
    localparam int LANE_W  = 9;
    localparam int DATA_W  = LANES * LANE_W;
    localparam int DEPTH   = 262144;
    localparam int BURST_W = 2;

    // ------------------------------------------------------------------
    // Reset values and burst step
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0]  DATA_RESET  = 36'h0;
    localparam logic [ADDR_W-1:0]  ADDR_RESET  = 18'h0;
    localparam logic [LANES-1:0]   BE_RESET    = 4'hf;
    localparam logic [BURST_W-1:0] BURST_RESET = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

    // ------------------------------------------------------------------
    // Operation held by each pipeline stage
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SNSP_IDLE,
        SNSP_READ,
        SNSP_WRITE
    } snsp_op_type;

endpackage : snsp_pkg

//--- src/snsp_burst_counter.sv
// Burst address counter for the two low address bits.
`timescale 1ns/10ps
module snsp_burst_counter (
    input wire logic          CLK,
    input wire logic          RST,
    input wire logic          ce,
    snsp_burst_if.counter     bif
);

    logic [snsp_pkg::BURST_W-1:0] start_reg;
    logic [snsp_pkg::BURST_W-1:0] start_next;
    logic [snsp_pkg::BURST_W-1:0] count_reg;
    logic [snsp_pkg::BURST_W-1:0] count_next;
    logic [snsp_pkg::BURST_W-1:0] step;

    // ------------------------------------------------------------------
    // Next beat; the two-bit sum wraps within four beats by width.
    // ------------------------------------------------------------------
    always_comb begin
        step       = count_reg + snsp_pkg::BURST_STEP;
        start_next = start_reg;
        count_next = count_reg;
        if (bif.load) begin
            bif.cur_bits = bif.start_bits;
        end else if (bif.linear) begin
            bif.cur_bits = start_reg + step; // R18
        end else begin
            bif.cur_bits = start_reg ^ step; // R18
        end
        if (ce) begin
            if (bif.load) begin
                start_next = bif.start_bits;
                count_next = snsp_pkg::BURST_RESET;
            end else if (bif.advance) begin
                count_next = step;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            start_reg <= snsp_pkg::BURST_RESET;
            count_reg <= snsp_pkg::BURST_RESET;
        end else begin
            start_reg <= start_next;
            count_reg <= count_next;
        end
    end

endmodule : snsp_burst_counter

//--- src/snsp_sram_port.sv
// Synchronous static RAM with late write and no bus turnaround cycle.
// Summary of operation
// R1 - Address, data and controls other than sleep and output enable are sampled only on rising clock edges.
// R2 - The burst-order strap is tied to a rail and never toggles.
// R3 - Sleep and output enable act asynchronously, without any clock edge.
// R4 - Output enable high turns data drivers off at any time, overriding reads.
// R5 - Writes start on a clock edge and commit internally, no write pulse.
// R6 - Pipelined mode registers read data once more, giving 3-1-1-1 latency.
// R7 - Flow-through mode bypasses the output register, giving 2-1-1-1 latency.
// R8 - A write may follow a read directly, with no deselect cycle.
// R9 - Write data follows its address by two cycles pipelined, one flow-through.
// R10 - Each 9-bit byte lane has its own active-low write strobe.
// R11 - Three independent chip selects allow depth expansion.
// R12 - The strap picks linear or interleaved burst order.
// R13 - Sleep request puts the device into power-down.
// R14 - Flow-through select low gives flow-through, high gives pipelined.
// R15 - Selected only with both low selects low and high select high.
// R16 - Clock gate input high makes the logic ignore clock edges.
// R17 - The host holds advance low to load an address for a new cycle.
// R18 - Burst steps the low two address bits, linear or interleaved, wrapping at four.
// R19 - Drivers stay off when deselected or writing; reads drive at mode latency.
`timescale 1ns/10ps
module snsp_sram_port (
    input wire logic                         CLK,
    input wire logic                         RST,
    input wire logic [snsp_pkg::ADDR_W-1:0]  ADDR,
    input wire logic                         WRITE_N,
    input wire logic                         BYTE_WRITE_LANE0_N,
    input wire logic                         BYTE_WRITE_LANE1_N,
    input wire logic                         BYTE_WRITE_LANE2_N,
    input wire logic                         BYTE_WRITE_LANE3_N,
    input wire logic                         CHIP_SELECT_LOW_A,
    input wire logic                         CHIP_SELECT_HIGH,
    input wire logic                         CHIP_SELECT_LOW_B,
    input wire logic                         ADVANCE_NOT_LOAD,
    input wire logic                         CLOCK_GATE_N,
    input wire logic                         OUTPUT_ENABLE_N,
    input wire logic                         SLEEP_REQUEST,
    input wire logic                         FLOW_THROUGH_SELECT_N,
    input wire logic                         BURST_ORDER_STRAP_N,
    input wire logic [snsp_pkg::DATA_W-1:0]  DATA_IN,
    output logic     [snsp_pkg::DATA_W-1:0]  DATA_OUT,
    output logic                             DATA_OE
);

    // ------------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------------
    logic [snsp_pkg::DATA_W-1:0]  mem [0:snsp_pkg::DEPTH-1];

    snsp_pkg::snsp_op_type         op_reg;
    snsp_pkg::snsp_op_type         op_next;
    logic [snsp_pkg::ADDR_W-1:0]   base_reg;
    logic [snsp_pkg::ADDR_W-1:0]   base_next;
    logic [snsp_pkg::ADDR_W-1:0]   wr1_addr_reg;
    logic [snsp_pkg::ADDR_W-1:0]   wr1_addr_next;
    logic [snsp_pkg::LANES-1:0]    wr1_be_reg;
    logic [snsp_pkg::LANES-1:0]    wr1_be_next;
    logic                          wr1_valid_reg;
    logic                          wr1_valid_next;
    logic [snsp_pkg::ADDR_W-1:0]   wr2_addr_reg;
    logic [snsp_pkg::ADDR_W-1:0]   wr2_addr_next;
    logic [snsp_pkg::LANES-1:0]    wr2_be_reg;
    logic [snsp_pkg::LANES-1:0]    wr2_be_next;
    logic                          wr2_valid_reg;
    logic                          wr2_valid_next;
    logic [snsp_pkg::ADDR_W-1:0]   rd_addr_reg;
    logic [snsp_pkg::ADDR_W-1:0]   rd_addr_next;
    logic [snsp_pkg::DATA_W-1:0]   rd_data_reg;
    logic [snsp_pkg::DATA_W-1:0]   rd_data_next;
    logic                          rd_valid_reg;
    logic                          rd_valid_next;
    logic [snsp_pkg::DATA_W-1:0]   data_out_reg;
    logic [snsp_pkg::DATA_W-1:0]   data_out_next;
    logic                          drive_reg;
    logic                          drive_next;

    logic                          ce;
    logic                          ft;
    logic                          selected;
    logic                          load;
    snsp_pkg::snsp_op_type         op_now;
    logic [snsp_pkg::ADDR_W-1:0]   cur_addr;
    logic [snsp_pkg::LANES-1:0]    be_now_n;
    logic                          commit_valid;
    logic [snsp_pkg::ADDR_W-1:0]   commit_addr;
    logic [snsp_pkg::LANES-1:0]    commit_be;
    logic [snsp_pkg::DATA_W-1:0]   commit_word;
    logic [snsp_pkg::DATA_W-1:0]   array_word;
    logic [snsp_pkg::DATA_W-1:0]   pl_word;

    snsp_burst_if bif ();

    snsp_burst_counter u_burst (
        .CLK (CLK),
        .RST (RST),
        .ce  (ce),
        .bif (bif.counter)
    );

    // ------------------------------------------------------------------
    // Byte-lane merge of late write data into a stored word.
    // ------------------------------------------------------------------
    function automatic logic [snsp_pkg::DATA_W-1:0] lane_merge(
        input logic [snsp_pkg::DATA_W-1:0] old_word,
        input logic [snsp_pkg::DATA_W-1:0] new_word,
        input logic [snsp_pkg::LANES-1:0]  lane_n
    );
        logic [snsp_pkg::DATA_W-1:0] result;
        result = old_word;
        for (int i = 0; i < snsp_pkg::LANES; i++) begin
            if (!lane_n[i]) begin
                result[i*snsp_pkg::LANE_W +: snsp_pkg::LANE_W] =
                    new_word[i*snsp_pkg::LANE_W +: snsp_pkg::LANE_W]; // R10
            end
        end
        return result;
    endfunction : lane_merge

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    // The strap is read live since it is a fixed rail; toggling it breaks bursts.
    always_comb begin
        ce       = !CLOCK_GATE_N; // R16
        ft       = !FLOW_THROUGH_SELECT_N; // R14
        selected = !CHIP_SELECT_LOW_A && CHIP_SELECT_HIGH && !CHIP_SELECT_LOW_B; // R11 R15
        load     = !ADVANCE_NOT_LOAD; // R17
        be_now_n = {BYTE_WRITE_LANE3_N, BYTE_WRITE_LANE2_N,
                    BYTE_WRITE_LANE1_N, BYTE_WRITE_LANE0_N};
        if (SLEEP_REQUEST) begin
            op_now = snsp_pkg::SNSP_IDLE; // R13
        end else if (load) begin
            if (!selected) begin
                op_now = snsp_pkg::SNSP_IDLE; // R15
            end else if (!WRITE_N) begin
                op_now = snsp_pkg::SNSP_WRITE; // R8
            end else begin
                op_now = snsp_pkg::SNSP_READ;
            end
        end else begin
            op_now = op_reg; // R18
        end
        bif.load       = load;
        bif.advance    = op_reg != snsp_pkg::SNSP_IDLE;
        bif.linear     = !BURST_ORDER_STRAP_N; // R12 R2
        bif.start_bits = ADDR[snsp_pkg::BURST_W-1:0];
        if (load) begin
            cur_addr = ADDR; // R1
        end else begin
            cur_addr = {base_reg[snsp_pkg::ADDR_W-1:snsp_pkg::BURST_W], bif.cur_bits};
        end
    end

    // ------------------------------------------------------------------
    // Late write commit and read forwarding
    // ------------------------------------------------------------------
    always_comb begin
        commit_valid = ft ? wr1_valid_reg : wr2_valid_reg; // R9
        commit_addr  = ft ? wr1_addr_reg : wr2_addr_reg;
        commit_be    = ft ? wr1_be_reg : wr2_be_reg;
        commit_word  = lane_merge(mem[commit_addr], DATA_IN, commit_be); // R5
        array_word   = mem[cur_addr];
        if (commit_valid && commit_addr == cur_addr) begin
            array_word = lane_merge(array_word, DATA_IN, commit_be);
        end
        pl_word = rd_data_reg;
        if (commit_valid && commit_addr == rd_addr_reg) begin
            pl_word = lane_merge(rd_data_reg, DATA_IN, commit_be);
        end
    end

    // ------------------------------------------------------------------
    // Pipeline next values; everything holds while the clock is gated.
    // ------------------------------------------------------------------
    always_comb begin
        op_next        = op_reg;
        base_next      = base_reg;
        wr1_addr_next  = wr1_addr_reg;
        wr1_be_next    = wr1_be_reg;
        wr1_valid_next = wr1_valid_reg;
        wr2_addr_next  = wr2_addr_reg;
        wr2_be_next    = wr2_be_reg;
        wr2_valid_next = wr2_valid_reg;
        rd_addr_next   = rd_addr_reg;
        rd_data_next   = rd_data_reg;
        rd_valid_next  = rd_valid_reg;
        data_out_next  = data_out_reg;
        drive_next     = drive_reg;
        if (ce) begin // R16
            op_next        = op_now;
            if (op_now != snsp_pkg::SNSP_IDLE) begin
                base_next = cur_addr;
            end
            wr1_valid_next = op_now == snsp_pkg::SNSP_WRITE;
            wr1_addr_next  = cur_addr;
            wr1_be_next    = be_now_n;
            wr2_valid_next = wr1_valid_reg; // R9
            wr2_addr_next  = wr1_addr_reg;
            wr2_be_next    = wr1_be_reg;
            rd_valid_next  = op_now == snsp_pkg::SNSP_READ;
            rd_addr_next   = cur_addr;
            rd_data_next   = array_word;
            if (ft) begin
                drive_next = op_now == snsp_pkg::SNSP_READ; // R7 R19
                if (op_now == snsp_pkg::SNSP_READ) begin
                    data_out_next = array_word; // R7
                end
            end else begin
                drive_next = rd_valid_reg; // R6 R19
                if (rd_valid_reg) begin
                    data_out_next = pl_word; // R6
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            op_reg        <= snsp_pkg::SNSP_IDLE;
            base_reg      <= snsp_pkg::ADDR_RESET;
            wr1_addr_reg  <= snsp_pkg::ADDR_RESET;
            wr1_be_reg    <= snsp_pkg::BE_RESET;
            wr1_valid_reg <= 1'b0;
            wr2_addr_reg  <= snsp_pkg::ADDR_RESET;
            wr2_be_reg    <= snsp_pkg::BE_RESET;
            wr2_valid_reg <= 1'b0;
            rd_addr_reg   <= snsp_pkg::ADDR_RESET;
            rd_data_reg   <= snsp_pkg::DATA_RESET;
            rd_valid_reg  <= 1'b0;
            data_out_reg  <= snsp_pkg::DATA_RESET;
            drive_reg     <= 1'b0;
        end else begin
            op_reg        <= op_next;
            base_reg      <= base_next;
            wr1_addr_reg  <= wr1_addr_next;
            wr1_be_reg    <= wr1_be_next;
            wr1_valid_reg <= wr1_valid_next;
            wr2_addr_reg  <= wr2_addr_next;
            wr2_be_reg    <= wr2_be_next;
            wr2_valid_reg <= wr2_valid_next;
            rd_addr_reg   <= rd_addr_next;
            rd_data_reg   <= rd_data_next;
            rd_valid_reg  <= rd_valid_next;
            data_out_reg  <= data_out_next;
            drive_reg     <= drive_next;
        end
    end

    // The array has no reset, as a real RAM powers up with unknown contents.
    always_ff @(posedge CLK) begin
        if (!RST && ce && commit_valid) begin
            mem[commit_addr] <= commit_word; // R5 R9
        end
    end

    // ------------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------------
    assign DATA_OUT = data_out_reg;
    assign DATA_OE  = drive_reg && !OUTPUT_ENABLE_N && !SLEEP_REQUEST; // R3 R4 R13

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    AST_OE_OVERRIDE: assert property ( // R4
        OUTPUT_ENABLE_N |-> !DATA_OE
    ) else $error("Data driven while output enable is off.");

    AST_SLEEP_QUIET: assert property ( // R13
        (ce && SLEEP_REQUEST) |=> op_reg == snsp_pkg::SNSP_IDLE && !wr1_valid_reg
    ) else $error("Operation accepted during sleep.");

    AST_FT_LATENCY: assert property ( // R7
        (ce && ft && op_now == snsp_pkg::SNSP_READ) |=> drive_reg && data_out_reg == $past(array_word)
    ) else $error("Flow-through read not driven one cycle after its address.");

    AST_PL_LATENCY: assert property ( // R6
        (ce && !ft && op_now == snsp_pkg::SNSP_READ) ##1 (ce && !ft) |=> drive_reg
    ) else $error("Pipelined read not driven two cycles after its address.");

    AST_FT_WRITE_QUIET: assert property ( // R19
        (ce && ft && op_now != snsp_pkg::SNSP_READ) |=> !drive_reg
    ) else $error("Drivers on after a flow-through write or deselect.");

    AST_DESELECT: assert property ( // R15
        (ce && load && !selected) |=> op_reg == snsp_pkg::SNSP_IDLE
    ) else $error("Command accepted while deselected.");

    AST_GATE_HOLD: assert property ( // R16
        CLOCK_GATE_N |=> $stable(data_out_reg) && $stable(drive_reg) && $stable(op_reg)
    ) else $error("State moved while the clock was gated.");

    AST_PL_WRITE_LAG: assert property ( // R9
        (ce && !ft && op_now == snsp_pkg::SNSP_WRITE) ##1 (ce && !ft) ##1 (ce && !ft) |->
            commit_valid && commit_addr == $past(cur_addr, 2)
    ) else $error("Pipelined write data not taken two cycles after its address.");

    AST_BURST_LINEAR: assert property ( // R18
        (ce && !load && !SLEEP_REQUEST && op_reg != snsp_pkg::SNSP_IDLE && bif.linear)
            |=> base_reg[1:0] == $past(base_reg[1:0]) + snsp_pkg::BURST_STEP
    ) else $error("Linear burst address did not step by one.");

    AST_LOAD_ADDR: assert property ( // R1
        (ce && load && op_now != snsp_pkg::SNSP_IDLE) |=> base_reg == $past(ADDR)
    ) else $error("Loaded address differs from the sampled address.");

endmodule : snsp_sram_port

//--- tb/snsp_host_model.sv
// Host controller model that drives commands and late write data into the port.
`timescale 1ns/10ps
module snsp_host_model (
    input wire logic    clk,
    output logic [17:0] addr,
    output logic        wr_n,
    output logic [3:0]  lanes_n,
    output logic [2:0]  sel,
    output logic        advance_not_load,
    output logic        gate_n,
    output logic        oe_n,
    output logic        sleep,
    output logic        ft_n,
    output logic        strap_n,
    output logic [35:0] din
);
    logic [35:0] wcur;
    logic [35:0] s1;
    logic [35:0] s2;

    initial begin
        addr = 18'h0;
        wr_n = 1'b1;
        lanes_n = 4'hf;
        sel = 3'h0;
        advance_not_load = 1'b0;
        gate_n = 1'b0;
        oe_n = 1'b0;
        sleep = 1'b0;
        ft_n = 1'b1;
        strap_n = 1'b0;
        wcur = 36'h0;
        s1 = 36'h0;
        s2 = 36'h0;
    end

    // Data trails its command by live edges only, so gated edges must not shift it.
    always @(posedge clk) begin
        if (!gate_n) begin
            s1 <= wcur;
            s2 <= s1;
        end
    end
    assign din = ft_n ? s2 : s1;

    // Outside write slots the bus carries the inverse of the last word, never a stale copy.
    task automatic beat(input logic a, input logic w, input logic [17:0] ad,
                        input logic [3:0] ln, input logic [2:0] cs, input logic [35:0] d);
        @(posedge clk);
        advance_not_load <= a;
        wr_n <= w;
        addr <= ad;
        lanes_n <= ln;
        sel <= cs;
        wcur <= w ? ~s1 : d;
    endtask : beat

    task automatic ctl(input logic g, input logic z, input logic o);
        gate_n <= g;
        sleep <= z;
        oe_n <= o;
    endtask : ctl

    // Mode and strap are only changed while the port is held in reset.
    task automatic mode(input logic f, input logic s);
        ft_n <= f;
        strap_n <= s;
    endtask : mode
endmodule : snsp_host_model

//--- tb/snsp_sram_port_test.sv
// Self-checking bench for the SRAM port with a reference memory and latency pipe.
`timescale 1ns/10ps
module snsp_sram_port_test;
    localparam logic [2:0] SEL = 3'h2;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    logic [17:0]           addr;
    logic                  wr_n, advance_not_load, gate_n, oe_n, sleep, ft_n, strap_n, oe, rs, ftm;
    logic [3:0]            lanes_n;
    logic [2:0]            sel;
    logic [35:0]           din, dout, od;
    logic [18:0]           rq [2] = '{19'h0, 19'h0};
    logic [22:0]           wq [2] = '{23'h0, 23'h0};
    logic [22:0]           wa;
    logic [18:0]           rv;
    logic [17:0]           base = 18'h0;
    logic [17:0]           ca;
    logic [1:0]            cnt = 2'h0;
    snsp_pkg::snsp_op_type op = snsp_pkg::SNSP_IDLE;
    logic [35:0]           mem [logic [17:0]];
    int                    fail_count = 0;
    int                    n_compared = 0;
    int                    cyc = 0;

    always #50 clk = ~clk;

    snsp_host_model u_host (.clk(clk), .addr(addr), .wr_n(wr_n), .lanes_n(lanes_n),
        .sel(sel), .advance_not_load(advance_not_load), .gate_n(gate_n), .oe_n(oe_n), .sleep(sleep), .ft_n(ft_n),
        .strap_n(strap_n), .din(din));

    snsp_sram_port u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WRITE_N(wr_n),
        .BYTE_WRITE_LANE0_N(lanes_n[0]), .BYTE_WRITE_LANE1_N(lanes_n[1]),
        .BYTE_WRITE_LANE2_N(lanes_n[2]), .BYTE_WRITE_LANE3_N(lanes_n[3]),
        .CHIP_SELECT_LOW_A(sel[2]), .CHIP_SELECT_HIGH(sel[1]), .CHIP_SELECT_LOW_B(sel[0]),
        .ADVANCE_NOT_LOAD(advance_not_load), .CLOCK_GATE_N(gate_n), .OUTPUT_ENABLE_N(oe_n),
        .SLEEP_REQUEST(sleep), .FLOW_THROUGH_SELECT_N(ft_n), .BURST_ORDER_STRAP_N(strap_n),
        .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe));

    // Reference decode of the pins as seen just before each rising edge.
    always @(posedge clk) begin
        cyc++;
        rs = rst;
        ftm = ft_n;
        if (cyc > 40000) begin
            fail_count++;
            stop_test();
        end
        if (rs) begin
            op = snsp_pkg::SNSP_IDLE;
            rq = '{19'h0, 19'h0};
            wq = '{23'h0, 23'h0};
        end else if (!gate_n) begin
            wa = ftm ? wq[1] : wq[0];
            if (wa[22]) begin
                od = mem.exists(wa[17:0]) ? mem[wa[17:0]] : 'x;
                for (int i = 0; i < 4; i++)
                    if (!wa[18+i])
                        od[9*i+:9] = din[9*i+:9];
                mem[wa[17:0]] = od;
            end
            if (sleep)
                op = snsp_pkg::SNSP_IDLE;
            else if (!advance_not_load) begin
                op = (sel != SEL) ? snsp_pkg::SNSP_IDLE :
                     wr_n ? snsp_pkg::SNSP_READ : snsp_pkg::SNSP_WRITE;
                base = addr;
                cnt = 2'h0;
            end else if (op != snsp_pkg::SNSP_IDLE)
                cnt = cnt + 2'h1;
            ca = {base[17:2], strap_n ? base[1:0] ^ cnt : base[1:0] + cnt};
            rq[1] = rq[0];
            rq[0] = {op == snsp_pkg::SNSP_READ, ca};
            wq[1] = wq[0];
            wq[0] = {op == snsp_pkg::SNSP_WRITE, lanes_n, ca};
        end
    end

    always @(negedge clk) begin
        if (cyc > 1 && rs) begin
            chk_flag("oe_in_reset", 1'b0, oe);
            chk_data("dout_in_reset", 36'h0, dout);
        end else if (cyc > 1) begin
            rv = ftm ? rq[1] : rq[0];
            chk_flag("oe", rv[18] & !oe_n & !sleep, oe);
            if (rv[18] && mem.exists(rv[17:0]))
                chk_data("rdata", mem[rv[17:0]], dout);
        end
    end

    task automatic chk_data(input string n, input logic [35:0] e, input logic [35:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_data

    task automatic chk_flag(input string n, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_flag

    task automatic wr(input logic [17:0] a, input logic [35:0] d);
        u_host.beat(1'b0, 1'b0, a, 4'h0, SEL, d);
    endtask : wr

    task automatic rd(input logic [17:0] a);
        u_host.beat(1'b0, 1'b1, a, 4'hf, SEL, 36'h0);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) u_host.beat(1'b0, 1'b1, 18'h0, 4'hf, 3'h0, 36'h0);
    endtask : idle

    task automatic run_suite(input logic f, input logic s, input logic [17:0] b);
        logic [2:0] cs [3] = '{3'h6, 3'h0, 3'h3};
        @(posedge clk);
        rst <= 1'b1;
        u_host.mode(f, s);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wr(b, 36'h1_2345_6789);
        rd(b);
        wr(b + 18'h1, 36'h9_8765_4321);
        rd(b + 18'h1);
        wr(b, 36'h5_5aa5_5aa5);
        rd(b);
        idle(3);
        $display("test read_write_mix done");
        wr(b + 18'h2, 36'h0);
        for (int i = 0; i < 4; i++)
            u_host.beat(1'b0, 1'b0, b + 18'h2, ~(4'h1 << i), SEL, {4{9'h1a5 + 9'(i)}});
        rd(b + 18'h2);
        idle(3);
        $display("test byte_lanes done");
        for (int i = 0; i < 4; i++)
            u_host.beat(i != 0, 1'b0, i == 0 ? b + 18'h6 : 18'h3ffff, 4'h0, SEL,
                        36'ha_0000_0000 + 36'(i));
        for (int i = 0; i < 4; i++)
            u_host.beat(i != 0, 1'b1, i == 0 ? b + 18'h5 : 18'h3ffff, 4'hf, SEL, 36'h0);
        idle(3);
        $display("test burst done");
        // A refused load must also keep a following advance idle.
        for (int j = 0; j < 3; j++) begin
            u_host.beat(1'b0, 1'b0, b, 4'h0, cs[j], 36'hb_adba_dbad);
            u_host.beat(1'b1, 1'b0, b, 4'h0, SEL, 36'hb_adba_dbad);
            rd(b);
        end
        idle(3);
        $display("test deselect done");
        rd(b);
        wr(b + 18'h1, 36'hd_eadb_eef0);
        u_host.ctl(1'b0, 1'b1, 1'b0);
        rd(b + 18'h1);
        u_host.ctl(1'b0, 1'b0, 1'b1);
        rd(b);
        u_host.ctl(1'b0, 1'b0, 1'b0);
        idle(3);
        $display("test sleep_and_output_enable done");
        rd(b + 18'h4);
        u_host.beat(1'b1, 1'b1, b, 4'hf, SEL, 36'h0);
        u_host.ctl(1'b1, 1'b0, 1'b0);
        repeat (2) u_host.beat(1'b1, 1'b1, b, 4'hf, SEL, 36'h0);
        u_host.ctl(1'b0, 1'b0, 1'b0);
        repeat (2) u_host.beat(1'b1, 1'b1, b, 4'hf, SEL, 36'h0);
        idle(4);
        $display("test clock_gate done");
    endtask : run_suite

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            run_suite(m[0], m[1], {m[1:0], 16'h0});
        end
        stop_test();
    end
endmodule : snsp_sram_port_test
